// ==== rtl/sdwl_pkg.sv ====
// Purpose: shared constants and types for the serial dac word loader
// Assumes: 16-bit frames, msb first
// Notes: no registers reachable by software
package sdwl_pkg;
    localparam int WORD_W = 16;
    localparam int CNT_W = 5;
    localparam logic [4:0] BITS_PER_WORD = 5'h10;
    localparam logic [4:0] CNT_RST = 5'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam int FIFO_DEPTH = 16;
    localparam logic [15:0] BIPOLAR_ZERO = 16'h8000;
    localparam logic [15:0] LOW14_MASK = 16'hFFFC;

    typedef struct packed {
        logic [15:0] word;
        logic auto_upd;
    } sdwl_word_t;

    typedef struct packed {
        logic [15:0] latch_code;
        logic [15:0] signed_code;
        logic [15:0] code14;
    } sdwl_dac_t;
endpackage : sdwl_pkg

// ==== rtl/sdwl_fifo.sv ====
// Purpose: synchronous fifo with valid/ready on both sides
// Assumes: single clock, depth a power of two
// Notes: full and empty derived from an extra pointer bit
`timescale 1ns/10ps
`default_nettype none
module sdwl_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    output logic [WIDTH-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic full, empty, do_wr, do_rd;

    always_comb
    begin
        full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
        empty = (wp_r == rp_r);
        do_wr = ce_in && wr_valid_in && !full;
        do_rd = ce_in && rd_ready_in && !empty;
        wp_nxt = do_wr ? wp_r + 1'b1 : wp_r;
        rp_nxt = do_rd ? rp_r + 1'b1 : rp_r;
        wr_ready_out = !full;
        rd_valid_out = !empty;
        rd_data_out = mem_r[rp_r[AW-1:0]];
    end

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            wp_r <= '0;
            rp_r <= '0;
        end
        else
        begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
        end
    end

    // storage carries no reset; only pointers define content
    always_ff @(posedge clk_in)
    begin
        if (do_wr)
        begin
            mem_r[wp_r[AW-1:0]] <= wr_data_in;
        end
    end
endmodule : sdwl_fifo
`default_nettype wire

// ==== rtl/sdwl_top.sv ====
// Purpose: serial word loader and dac latch control
// Assumes: link clock is the host shift clock, stops outside frames
// Notes: link side shifts on falling edges; words cross by toggle handshake
// How it works
// - the link is shift clock, serial data, an active-low frame strobe and an active-low load strobe.
// - each frame carries a 16-bit word sampled on falling shift clock edges.
// - the dac latch updates automatically on the last bit or on the load strobe.
// - unipolar coding is straight binary of the latch code.
// - bipolar coding is offset binary, 0x8000 being zero.
// - the 14-bit variant uses only the top 14 bits of the latch.
// - with chain off only 16 bits are taken, later clocks are ignored.
// - words go msb first; the 14-bit variant ends with two zero bits.
// - the load strobe sampled at frame start selects auto or strobe update.
// - with chain on every falling edge shifts, overflow leaves on chain_out.
`timescale 1ns/10ps
`default_nettype none
module sdwl_top (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    input wire logic shift_clk_in,
    input wire logic serial_in,
    input wire logic frame_n_in,
    input wire logic load_strobe_n_in,
    input wire logic chain_enable_in,
    input wire logic bipolar_in,
    output logic chain_out,
    output logic [15:0] latch_code_out,
    output logic [15:0] signed_code_out,
    output logic [15:0] code14_out,
    output logic latch_upd_out,
    output logic word_ready_out
);
    // ---- link domain, falling edges of the shift clock ----
    logic [15:0] sh_r, sh_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic mode_r, mode_nxt;
    logic tgl_r, tgl_nxt;
    logic [15:0] cap_r, cap_nxt;
    logic capm_r, capm_nxt;
    logic out_r, out_nxt;
    logic first;
    logic done;

    always_comb
    begin
        sh_nxt = sh_r;
        cnt_nxt = cnt_r;
        mode_nxt = mode_r;
        tgl_nxt = tgl_r;
        cap_nxt = cap_r;
        capm_nxt = capm_r;
        out_nxt = out_r;
        first = (cnt_r == sdwl_pkg::CNT_RST);
        done = (cnt_r == sdwl_pkg::BITS_PER_WORD);
        if (first)
        begin
            mode_nxt = !load_strobe_n_in;
        end
        if (chain_enable_in || !done)
        begin
            out_nxt = sh_r[15];
            sh_nxt = {sh_r[14:0], serial_in};
            if (!done)
            begin
                cnt_nxt = cnt_r + 5'h01;
            end
            if (cnt_r == sdwl_pkg::BITS_PER_WORD - 5'h01)
            begin
                // word complete on the 16th falling edge
                cap_nxt = {sh_r[14:0], serial_in};
                capm_nxt = first ? !load_strobe_n_in : mode_r;
                tgl_nxt = !tgl_r;
            end
        end
    end

    // frame strobe high resets the bit counter and mode; clock may be stopped then
    // core reset clears it too, so a frame strobe already high at start-up is safe
    always_ff @(negedge shift_clk_in or posedge frame_n_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            cnt_r <= sdwl_pkg::CNT_RST;
            mode_r <= 1'b0;
        end
        else if (frame_n_in)
        begin
            cnt_r <= sdwl_pkg::CNT_RST;
            mode_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            mode_r <= mode_nxt;
        end
    end

    always_ff @(negedge shift_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            sh_r <= sdwl_pkg::WORD_RST;
            tgl_r <= 1'b0;
            cap_r <= sdwl_pkg::WORD_RST;
            capm_r <= 1'b0;
            out_r <= 1'b0;
        end
        else if (!frame_n_in)
        begin
            sh_r <= sh_nxt;
            tgl_r <= tgl_nxt;
            cap_r <= cap_nxt;
            capm_r <= capm_nxt;
            out_r <= out_nxt;
        end
    end

    // ---- core domain ----
    logic [2:0] tgl_s_r;
    logic [1:0] ld_s_r;
    logic ld_d_r;
    logic ld_fall;
    logic push;
    logic fifo_rdy;
    logic [16:0] fifo_q;
    logic fifo_v;
    logic pop;
    logic [15:0] latch_r, latch_nxt;
    logic upd_r, upd_nxt;
    logic [1:0] co_s_r;
    sdwl_pkg::sdwl_word_t wr_w, rd_w;
    sdwl_pkg::sdwl_dac_t dac;

    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            tgl_s_r <= 3'h0;
            // low after reset: a strobe tied low must not look like a fresh fall
            ld_s_r <= 2'h0;
            ld_d_r <= 1'b0;
            co_s_r <= 2'h0;
        end
        else if (ce_in)
        begin
            tgl_s_r <= {tgl_s_r[1:0], tgl_r};
            ld_s_r <= {ld_s_r[0], load_strobe_n_in};
            ld_d_r <= ld_s_r[1];
            co_s_r <= {co_s_r[0], out_r};
        end
    end

    // cap_r is stable for many core cycles after the toggle flips
    always_comb
    begin
        push = ce_in && (tgl_s_r[2] != tgl_s_r[1]);
        wr_w.word = cap_r;
        wr_w.auto_upd = capm_r;
        ld_fall = ld_d_r && !ld_s_r[1];
        rd_w = sdwl_pkg::sdwl_word_t'(fifo_q);
        // auto words load at once; others wait for the strobe edge
        pop = fifo_v && (rd_w.auto_upd || ld_fall);
        latch_nxt = pop ? rd_w.word : latch_r;
        upd_nxt = pop;
    end

    sdwl_fifo #(
        .WIDTH(17),
        .DEPTH(sdwl_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_in(core_clk_in),
        .arst_n_in(arst_n_in),
        .ce_in(ce_in),
        .wr_data_in(wr_w),
        .wr_valid_in(push),
        .wr_ready_out(fifo_rdy),
        .rd_data_out(fifo_q),
        .rd_valid_out(fifo_v),
        .rd_ready_in(pop)
    );

    // a full fifo drops the word: the link has no back-pressure pin
    always_comb
    begin
        dac.latch_code = latch_r;
        dac.signed_code = latch_r ^ sdwl_pkg::BIPOLAR_ZERO;
        dac.code14 = latch_r & sdwl_pkg::LOW14_MASK;
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            latch_r <= sdwl_pkg::WORD_RST;
            upd_r <= 1'b0;
            latch_code_out <= sdwl_pkg::WORD_RST;
            signed_code_out <= sdwl_pkg::WORD_RST;
            code14_out <= sdwl_pkg::WORD_RST;
            latch_upd_out <= 1'b0;
            word_ready_out <= 1'b0;
            chain_out <= 1'b0;
        end
        else if (ce_in)
        begin
            latch_r <= latch_nxt;
            upd_r <= upd_nxt;
            latch_code_out <= dac.latch_code;
            signed_code_out <= bipolar_in ? dac.signed_code : dac.latch_code;
            code14_out <= dac.code14;
            latch_upd_out <= upd_r;
            word_ready_out <= fifo_v && fifo_rdy;
            chain_out <= co_s_r[1];
        end
    end
endmodule : sdwl_top
`default_nettype wire

// ==== verification/sdwl_top_assertions.sv ====
// Purpose: port checks for the word loader
// Assumes: core clock domain only
// Notes: link pins are async to the core, so the bench judges them
`timescale 1ns/10ps
`default_nettype none
module sdwl_top_assertions (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    input wire logic load_strobe_n_in,
    input wire logic bipolar_in,
    input wire logic [15:0] latch_code_out,
    input wire logic [15:0] signed_code_out,
    input wire logic [15:0] code14_out,
    input wire logic latch_upd_out,
    input wire logic word_ready_out
);
    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (!arst_n_in);
    a_upd_one_pulse: assert property (latch_upd_out |=> !latch_upd_out [*3])
        else $error("update pulse too long");
    a_change_then_upd: assert property ($changed(latch_code_out) |-> latch_upd_out)
        else $error("latch moved without update");
    a_code14_mask: assert property (code14_out == (latch_code_out & 16'hFFFC))
        else $error("code14 view wrong");
    a_straight_view: assert property (!bipolar_in [*3] |-> signed_code_out == latch_code_out)
        else $error("straight view wrong");
    a_offset_view: assert property (bipolar_in [*3] |-> signed_code_out == (latch_code_out ^ 16'h8000))
        else $error("offset view wrong");
    a_strobe_load: assert property ($fell(load_strobe_n_in) && word_ready_out |-> ##[3:7] latch_upd_out)
        else $error("strobe did not load");
    a_no_stray_upd: assert property (load_strobe_n_in [*8] |-> !latch_upd_out)
        else $error("update without strobe");
    a_ce_freeze: assert property (!ce_in |=> $stable(latch_code_out) && $stable(latch_upd_out))
        else $error("state moved while halted");
    c_auto: cover property (latch_upd_out && !load_strobe_n_in);
    c_strobe: cover property ($fell(load_strobe_n_in) ##[3:7] latch_upd_out);
    c_full: cover property ($fell(word_ready_out));
endmodule : sdwl_top_assertions
bind sdwl_top sdwl_top_assertions u_sdwl_top_assertions (.core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in), .ce_in(ce_in), .load_strobe_n_in(load_strobe_n_in),
    .bipolar_in(bipolar_in), .latch_code_out(latch_code_out),
    .signed_code_out(signed_code_out), .code14_out(code14_out),
    .latch_upd_out(latch_upd_out), .word_ready_out(word_ready_out));
`default_nettype wire

// ==== verification/sdwl_host_model.sv ====
// Purpose: host serial port driving the link
// Assumes: clock idles low, data moves on rising edges
// Notes: link clock runs only inside frames
`timescale 1ns/10ps
`default_nettype none
module sdwl_host_model (
    output logic shift_clk_out,
    output logic data_out,
    output logic frame_n_out,
    output logic load_n_out
);
    initial
    begin
        shift_clk_out = 1'b0;
        data_out = 1'b0;
        frame_n_out = 1'b1;
        load_n_out = 1'b0;
    end
    task automatic send(input logic [31:0] bits, input int n, input logic auto_md);
        load_n_out = !auto_md;
        #7 frame_n_out = 1'b0;
        #9;
        for (int i = n - 1; i >= 0; i--)
        begin
            shift_clk_out = 1'b1;
            data_out = bits[i];
            #6 shift_clk_out = 1'b0;
            #6;
            if (i == n - 8)
                #20;
        end
        data_out = !data_out; // released line must not keep the last bit
        #15 frame_n_out = 1'b1;
    endtask : send
    task automatic pulse_load();
        load_n_out = 1'b0;
        #100 load_n_out = 1'b1;
    endtask : pulse_load
endmodule : sdwl_host_model
`default_nettype wire

// ==== verification/tb.sv ====
// Purpose: scenario bench for the word loader
// Assumes: host model drives the link
// Notes: strobe mode is used to fill the fifo
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic core_clk_in, arst_n_in, ce_in, chain_en, bip;
    logic sclk, sdat, frame_n, load_n, chain_q, upd, ready;
    logic [15:0] lc, sc, c14;
    int failures = 0;
    int n_tests = 0;
    sdwl_host_model u_sdwl_host_model (.shift_clk_out(sclk), .data_out(sdat),
        .frame_n_out(frame_n), .load_n_out(load_n));
    sdwl_top u_sdwl_top (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .ce_in(ce_in),
        .shift_clk_in(sclk), .serial_in(sdat), .frame_n_in(frame_n),
        .load_strobe_n_in(load_n), .chain_enable_in(chain_en), .bipolar_in(bip),
        .chain_out(chain_q), .latch_code_out(lc), .signed_code_out(sc),
        .code14_out(c14), .latch_upd_out(upd), .word_ready_out(ready));
    initial
    begin
        core_clk_in = 1'b0;
        forever #25 core_clk_in = ~core_clk_in;
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wait_upd();
        int k;
        for (k = 0; k < 40 && upd !== 1'b1; k++)
            @(negedge core_clk_in);
        if (k == 40)
        begin
            failures++;
            stop_test();
        end
        repeat (4) @(negedge core_clk_in);
    endtask : wait_upd
    task automatic s_auto(input logic [31:0] bits, input int n, input logic [15:0] w,
        input logic ch);
        u_sdwl_host_model.send(bits, n, 1'b1);
        wait_upd();
        chk("latch", lc, w);
        chk("code14", c14, w & 16'hFFFC);
        chk("signed", sc, w ^ {bip, 15'h0000});
        if (n > 16)
            chk("chain", {15'h0000, chain_q}, {15'h0000, ch});
    endtask : s_auto
    task automatic s_freeze(input logic [15:0] w, input logic [15:0] old);
        ce_in = 1'b0;
        u_sdwl_host_model.send({16'h0000, w}, 16, 1'b1);
        repeat (8) @(negedge core_clk_in);
        chk("frozen", lc, old);
        ce_in = 1'b1;
        wait_upd();
        chk("thawed", lc, w);
    endtask : s_freeze
    task automatic s_fill();
        for (int i = 0; i < 17; i++)
        begin
            u_sdwl_host_model.send({16'h0000, 16'h1000 + 16'(i)}, 16, 1'b0);
            repeat (10) @(negedge core_clk_in);
        end
        chk("held", lc, 16'h3C5A);
        chk("full", {15'h0000, ready}, 16'h0000);
        for (int i = 0; i < 16; i++)
        begin
            u_sdwl_host_model.pulse_load();
            wait_upd();
            chk("drain", lc, 16'h1000 + 16'(i));
        end
        chk("empty", {15'h0000, ready}, 16'h0000);
    endtask : s_fill
    initial
    begin
        arst_n_in = 1'b1;
        #1;
        arst_n_in = 1'b0;
        ce_in = 1'b1;
        chain_en = 1'b0;
        bip = 1'b0;
        repeat (3) @(negedge core_clk_in);
        arst_n_in = 1'b1;
        repeat (4) @(negedge core_clk_in);
        s_auto({16'h0000, 16'hFFFF}, 16, 16'hFFFF, 1'b0);
        s_auto({16'h0000, 16'h0001}, 16, 16'h0001, 1'b0);
        s_auto({12'h000, 16'hA5C3, 4'hF}, 20, 16'hA5C3, 1'b1);
        bip = 1'b1;
        repeat (3) @(negedge core_clk_in);
        s_auto({16'h0000, 16'h8000}, 16, 16'h8000, 1'b0);
        s_auto({16'h0000, 16'h0000}, 16, 16'h0000, 1'b0);
        chain_en = 1'b1;
        s_auto({12'h000, 16'h3C5A, 4'h6}, 20, 16'h3C5A, 1'b1);
        chain_en = 1'b0;
        ce_in = 1'b0;
        repeat (3) @(negedge core_clk_in);
        ce_in = 1'b1;
        s_fill();
        s_freeze(16'h5A3C, 16'h100F);
        stop_test();
    end
endmodule : tb
`default_nettype wire
